// ==== rtl/ppr_pkg.sv ====
// ppr_pkg: constants shared by the parallel receive port and its byte store
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus
package ppr_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_GLOBAL_CONFIG  = 8'h00;
	localparam logic [7:0] ADDR_CHANNEL_CMD    = 8'h04;
	localparam logic [7:0] ADDR_TX_BAUD_PERIOD = 8'h08;
	localparam logic [7:0] ADDR_RX_CLOCK_OPT   = 8'h0C;
	localparam logic [7:0] ADDR_RX_BAUD_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_RX_THRESHOLD   = 8'h14;
	localparam logic [7:0] ADDR_STATUS         = 8'h18;
	localparam logic [7:0] ADDR_RX_DATA        = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int GCR_PARALLEL_BIT = 7;
	localparam int CMD_RX_DIS_BIT   = 0;
	localparam int CMD_RX_EN_BIT    = 1;
	localparam int CMD_TX_DIS_BIT   = 2;
	localparam int CMD_TX_EN_BIT    = 3;
	localparam int ST_BUSY_BIT      = 0;
	localparam int ST_STROBE_BIT    = 1;
	localparam int ST_FULL_BIT      = 2;
	localparam int ST_EMPTY_BIT     = 3;
	localparam int ST_SREQ_BIT      = 4;
	localparam int ST_RXEN_BIT      = 5;
	localparam int ST_TXEN_BIT      = 6;
	localparam int ST_COUNT_LSB     = 8;

	// ----------------------------------------------------------------
	// sizes, reset values, answers
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH       = 30;
	localparam int FIFO_WIDTH       = 8;
	localparam int FIFO_CW          = 5;
	localparam int PULSE_CW         = 5;
	localparam logic [4:0] THRESH_MIN   = 5'h01;
	localparam logic [4:0] THRESH_MAX   = 5'h1E;
	localparam logic [4:0] THRESH_RESET = 5'h01;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// bit engine clock sources: divide ratios for option 0..4
	localparam int DIV_W = 11;
	localparam logic [DIV_W-1:0] DIV_8    = 11'h007;
	localparam logic [DIV_W-1:0] DIV_32   = 11'h01F;
	localparam logic [DIV_W-1:0] DIV_128  = 11'h07F;
	localparam logic [DIV_W-1:0] DIV_512  = 11'h1FF;
	localparam logic [DIV_W-1:0] DIV_2048 = 11'h7FF;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_HALF  = 5'b00010,
		RX_TRAIL = 5'b00100,
		RX_STALL = 5'b01000,
		RX_ACK   = 5'b10000
	} ppr_rx_state_t;

endpackage : ppr_pkg

// ==== rtl/ppr_fifo_if.sv ====
// ppr_fifo_if: push/pop signals between the receive engine and the byte store
// assumes both ends sit on the same aclk
`timescale 1ns/100ps
interface ppr_fifo_if;
	logic                             push;
	logic [ppr_pkg::FIFO_WIDTH-1:0]   push_data;
	logic                             pop;
	logic [ppr_pkg::FIFO_WIDTH-1:0]   pop_data;
	logic                             full;
	logic                             empty;
	logic [ppr_pkg::FIFO_CW-1:0]      count;

	modport engine (output push, output push_data, output pop,
	                input pop_data, input full, input empty, input count);
	modport store  (input push, input push_data, input pop,
	                output pop_data, output full, output empty, output count);
endinterface : ppr_fifo_if

// ==== rtl/ppr_fifo.sv ====
// ppr_fifo: merged byte store of the parallel channel, flip-flop storage
// assumes push is never raised while full nor pop while empty
`timescale 1ns/100ps
module ppr_fifo #(
	parameter int DEPTH = ppr_pkg::FIFO_DEPTH,
	parameter int CW    = ppr_pkg::FIFO_CW
) (
	input wire logic   aclk,
	input wire logic   aresetn,
	ppr_fifo_if.store  f
);
	logic [ppr_pkg::FIFO_WIDTH-1:0] mem_r [DEPTH];
	logic [CW-1:0]                  wr_ptr_r;
	logic [CW-1:0]                  rd_ptr_r;
	logic [CW-1:0]                  count_r;

	function automatic logic [CW-1:0] wrap_inc(input logic [CW-1:0] p);
		wrap_inc = (p == CW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : wrap_inc

	always_ff @(posedge aclk)
	begin
		if (f.push)
			mem_r[wr_ptr_r] <= f.push_data;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end
		else
		begin
			if (f.push)
				wr_ptr_r <= wrap_inc(wr_ptr_r);
			if (f.pop)
				rd_ptr_r <= wrap_inc(rd_ptr_r);
			if (f.push && !f.pop)
				count_r <= count_r + 1'b1;
			else if (f.pop && !f.push)
				count_r <= count_r - 1'b1;
		end
	end

	assign f.pop_data = mem_r[rd_ptr_r];
	assign f.full     = (count_r == CW'(DEPTH));
	assign f.empty    = (count_r == '0);
	assign f.count    = count_r;
endmodule : ppr_fifo

// ==== rtl/ppr_top.sv ====
// ppr_top: receive side of the byte-wide parallel channel with AXI4-Lite registers
// assumes the sender keeps data stable from its strobe until our acknowledge
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps

module ppr_top #(
	parameter int DEPTH = ppr_pkg::FIFO_DEPTH
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  port_data_in,
	input  wire logic        port_ack_in_n,
	output logic             port_busy_out,
	output logic             port_strobe_out_n,
	output logic             rx_service_req
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ppr_fifo_if fifo ();

	logic       parallel_mode_r;
	logic       rx_en_r;
	logic       tx_en_r;
	logic [7:0] tx_baud_period_r;
	logic [7:0] tx_period_shadow_r;
	logic [2:0] rx_clock_option_r;
	logic [7:0] rx_baud_period_r;
	logic [4:0] rx_threshold_r;

	logic [2:0] ack_sync_r;
	logic       ack_lvl_r;
	logic [7:0] data_s1_r;
	logic [7:0] data_s2_r;
	logic [7:0] data_s3_r;

	ppr_pkg::ppr_rx_state_t state_r;
	logic [ppr_pkg::DIV_W-1:0] div_cnt_r;
	logic [7:0]                half_cnt_r;
	logic [ppr_pkg::PULSE_CW-1:0] pulse_cnt_r;
	logic                      half_clk_r;
	logic [7:0]                byte_r;

	logic aw_got_r, w_got_r;
	logic [7:0]  awaddr_q_r;
	logic [31:0] wdata_q_r;
	logic [3:0]  wstrb_q_r;

	logic ack_active;
	logic engine_on;
	logic bit_tick;
	logic aw_take, w_take, ar_take, wr_do;
	logic aw_got_nxt, w_got_nxt, bvalid_nxt;
	logic [7:0]  wa;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic        rd_pop;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [ppr_pkg::DIV_W-1:0] div_limit(input logic [2:0] opt);
		unique case (opt)
			3'h0:    div_limit = ppr_pkg::DIV_8;
			3'h1:    div_limit = ppr_pkg::DIV_32;
			3'h2:    div_limit = ppr_pkg::DIV_128;
			3'h3:    div_limit = ppr_pkg::DIV_512;
			default: div_limit = ppr_pkg::DIV_2048;
		endcase
	endfunction : div_limit

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  strb);
		for (int i = 0; i < 4; i++)
			lane_merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign aw_take    = s_axi_awvalid && s_axi_awready;
	assign w_take     = s_axi_wvalid && s_axi_wready;
	assign wr_do      = (aw_got_r || aw_take) && (w_got_r || w_take);
	assign aw_got_nxt = (aw_got_r || aw_take) && !wr_do;
	assign w_got_nxt  = (w_got_r || w_take) && !wr_do;
	assign bvalid_nxt = wr_do || (s_axi_bvalid && !s_axi_bready);
	assign wa         = aw_take ? s_axi_awaddr : awaddr_q_r;
	assign wd         = w_take ? s_axi_wdata : wdata_q_r;
	assign ws         = w_take ? s_axi_wstrb : wstrb_q_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			awaddr_q_r    <= 8'h00;
			wdata_q_r     <= 32'h0000_0000;
			wstrb_q_r     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ppr_pkg::RESP_OKAY;
		end
		else
		begin
			aw_got_r      <= aw_got_nxt;
			w_got_r       <= w_got_nxt;
			s_axi_awready <= !aw_got_nxt && !bvalid_nxt;
			s_axi_wready  <= !w_got_nxt && !bvalid_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			if (aw_take)
				awaddr_q_r <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_q_r <= s_axi_wdata;
				wstrb_q_r <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				unique case (wa)
					ppr_pkg::ADDR_GLOBAL_CONFIG, ppr_pkg::ADDR_CHANNEL_CMD,
					ppr_pkg::ADDR_TX_BAUD_PERIOD, ppr_pkg::ADDR_RX_CLOCK_OPT,
					ppr_pkg::ADDR_RX_BAUD_PERIOD, ppr_pkg::ADDR_RX_THRESHOLD,
					ppr_pkg::ADDR_STATUS, ppr_pkg::ADDR_RX_DATA:
						s_axi_bresp <= ppr_pkg::RESP_OKAY;
					default:
						s_axi_bresp <= ppr_pkg::RESP_SLVERR;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			parallel_mode_r    <= 1'b0;  // serial after reset
			rx_en_r            <= 1'b0;
			tx_en_r            <= 1'b0;
			tx_baud_period_r   <= 8'h00;
			tx_period_shadow_r <= 8'h00;
			rx_clock_option_r  <= 3'h0;
			rx_baud_period_r   <= 8'h00;
			rx_threshold_r     <= ppr_pkg::THRESH_RESET;
		end
		else if (wr_do && ws[0])
		begin
			unique case (wa)
				ppr_pkg::ADDR_GLOBAL_CONFIG:
					parallel_mode_r <= wd[ppr_pkg::GCR_PARALLEL_BIT];
				ppr_pkg::ADDR_CHANNEL_CMD:
				begin
					if (wd[ppr_pkg::CMD_RX_EN_BIT])
						rx_en_r <= 1'b1;
					else if (wd[ppr_pkg::CMD_RX_DIS_BIT])
						rx_en_r <= 1'b0;
					if (wd[ppr_pkg::CMD_TX_EN_BIT])
						tx_en_r <= 1'b1;
					else if (wd[ppr_pkg::CMD_TX_DIS_BIT])
						tx_en_r <= 1'b0;
					// width changes only take effect on (re)enable
					if (wd[ppr_pkg::CMD_RX_EN_BIT] || wd[ppr_pkg::CMD_TX_EN_BIT])
						tx_period_shadow_r <= tx_baud_period_r;
				end
				ppr_pkg::ADDR_TX_BAUD_PERIOD:
					tx_baud_period_r <= wd[7:0];
				ppr_pkg::ADDR_RX_CLOCK_OPT:
					rx_clock_option_r <= wd[2:0];
				ppr_pkg::ADDR_RX_BAUD_PERIOD:
					rx_baud_period_r <= wd[7:0];
				ppr_pkg::ADDR_RX_THRESHOLD:
				begin
					// out-of-range values leave the threshold unchanged
					if (wd[4:0] >= ppr_pkg::THRESH_MIN && wd[4:0] <= ppr_pkg::THRESH_MAX
					    && wd[7:5] == 3'h0)
						rx_threshold_r <= wd[4:0];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel; reading the data word pops one byte
	// ----------------------------------------------------------------
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_pop  = ar_take && (s_axi_araddr == ppr_pkg::ADDR_RX_DATA) && !fifo.empty;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= ppr_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !ar_take && (!s_axi_rvalid || s_axi_rready);
			if (ar_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= ppr_pkg::RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				unique case (s_axi_araddr)
					ppr_pkg::ADDR_GLOBAL_CONFIG:
						s_axi_rdata[ppr_pkg::GCR_PARALLEL_BIT] <= parallel_mode_r;
					ppr_pkg::ADDR_CHANNEL_CMD: ;  // commands read back as zero
					ppr_pkg::ADDR_TX_BAUD_PERIOD: s_axi_rdata[7:0] <= tx_baud_period_r;
					ppr_pkg::ADDR_RX_CLOCK_OPT:   s_axi_rdata[2:0] <= rx_clock_option_r;
					ppr_pkg::ADDR_RX_BAUD_PERIOD: s_axi_rdata[7:0] <= rx_baud_period_r;
					ppr_pkg::ADDR_RX_THRESHOLD:   s_axi_rdata[4:0] <= rx_threshold_r;
					ppr_pkg::ADDR_STATUS:
					begin
						s_axi_rdata[ppr_pkg::ST_BUSY_BIT]   <= port_busy_out;
						s_axi_rdata[ppr_pkg::ST_STROBE_BIT] <= !port_strobe_out_n;
						s_axi_rdata[ppr_pkg::ST_FULL_BIT]   <= fifo.full;
						s_axi_rdata[ppr_pkg::ST_EMPTY_BIT]  <= fifo.empty;
						s_axi_rdata[ppr_pkg::ST_SREQ_BIT]   <= rx_service_req;
						s_axi_rdata[ppr_pkg::ST_RXEN_BIT]   <= rx_en_r;
						s_axi_rdata[ppr_pkg::ST_TXEN_BIT]   <= tx_en_r;
						s_axi_rdata[ppr_pkg::ST_COUNT_LSB +: ppr_pkg::FIFO_CW] <= fifo.count;
					end
					ppr_pkg::ADDR_RX_DATA:
						if (!fifo.empty)
							s_axi_rdata[7:0] <= fifo.pop_data;
					default:
						s_axi_rresp <= ppr_pkg::RESP_SLVERR;
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers: three stages, an ack change is accepted when the last two agree
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ack_sync_r <= 3'b111;
			ack_lvl_r  <= 1'b1;
			data_s1_r  <= 8'h00;
			data_s2_r  <= 8'h00;
			data_s3_r  <= 8'h00;
		end
		else
		begin
			ack_sync_r <= {ack_sync_r[1:0], port_ack_in_n};
			if (ack_sync_r[1] == ack_sync_r[2])
				ack_lvl_r <= ack_sync_r[2];
			data_s1_r <= port_data_in;
			data_s2_r <= data_s1_r;
			data_s3_r <= data_s2_r;
		end
	end

	assign ack_active = !ack_lvl_r;
	assign engine_on  = parallel_mode_r && rx_en_r;

	// ----------------------------------------------------------------
	// bit engine clock source and clk/2 pulse clock
	// ----------------------------------------------------------------
	assign bit_tick = (div_cnt_r == div_limit(rx_clock_option_r));

	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_r != ppr_pkg::RX_HALF || bit_tick)
			div_cnt_r <= '0;
		else
			div_cnt_r <= div_cnt_r + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			half_clk_r <= 1'b0;
		else
			half_clk_r <= !half_clk_r;
	end

	// ----------------------------------------------------------------
	// receive handshake engine
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r           <= ppr_pkg::RX_IDLE;
			half_cnt_r        <= 8'h00;
			pulse_cnt_r       <= '0;
			byte_r            <= 8'h00;
			port_busy_out     <= 1'b0;
			port_strobe_out_n <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				ppr_pkg::RX_IDLE:
					if (engine_on && ack_active)
					begin
						port_busy_out <= 1'b1;
						// half a bit: half the baud period in source ticks
						half_cnt_r    <= (rx_baud_period_r > 8'h01) ? (rx_baud_period_r >> 1)
						                                            : 8'h01;
						state_r       <= ppr_pkg::RX_HALF;
					end
				ppr_pkg::RX_HALF:
					if (bit_tick)
					begin
						if (half_cnt_r == 8'h01)
						begin
							byte_r <= data_s3_r;
							if (ack_active)
								state_r <= ppr_pkg::RX_TRAIL;
							else
								state_r <= ppr_pkg::RX_STALL;  // capture now
						end
						else
							half_cnt_r <= half_cnt_r - 1'b1;
					end
				ppr_pkg::RX_TRAIL:
					if (!ack_active)
						state_r <= ppr_pkg::RX_STALL;
				ppr_pkg::RX_STALL:
					// busy stays high, no acknowledge while the store is full
					if (!fifo.full)
					begin
						port_strobe_out_n <= 1'b0;
						// timer from shadow only, no clock option involved
						pulse_cnt_r       <= tx_period_shadow_r[ppr_pkg::PULSE_CW-1:0];
						state_r           <= ppr_pkg::RX_ACK;
					end
				ppr_pkg::RX_ACK:
					if (half_clk_r)
					begin
						if (pulse_cnt_r <= 5'h01)
						begin
							port_strobe_out_n <= 1'b1;
							port_busy_out     <= 1'b0;
							state_r           <= ppr_pkg::RX_IDLE;
						end
						else
							pulse_cnt_r <= pulse_cnt_r - 1'b1;
					end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// byte store and service request
	// ----------------------------------------------------------------
	assign fifo.push      = (state_r == ppr_pkg::RX_STALL) && !fifo.full;
	assign fifo.push_data = byte_r;
	assign fifo.pop       = rd_pop;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_service_req <= 1'b0;
		else
			rx_service_req <= engine_on && (fifo.count == rx_threshold_r);
	end

	ppr_fifo #(
		.DEPTH (DEPTH),
		.CW    (ppr_pkg::FIFO_CW)
	) u_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.f       (fifo)
	);
endmodule : ppr_top

// ==== tb/ppr_top_asserts.sv ====
// ppr_top_asserts: port-level checks of the parallel receive port
// assumes one aclk domain; bound onto ppr_top at the foot of this file
`timescale 1ns/100ps
module ppr_top_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        port_ack_in_n,
	input wire logic        port_busy_out,
	input wire logic        port_strobe_out_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ------
	// handshake pins
	// ------
	property p_ack_busy;
		!port_strobe_out_n |-> port_busy_out;
	endproperty
	a_ack_busy: assert property (p_ack_busy)
		else $error("ack low while busy low");
	property p_drop;
		$rose(port_strobe_out_n) |-> !port_busy_out;
	endproperty
	a_drop: assert property (p_drop)
		else $error("busy outlived ack");
	property p_busy_hold;
		$fell(port_busy_out) |-> $past(!port_strobe_out_n);
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped without ack");
	// 5-bit count at clk/2 caps the pulse near 62 cycles
	property p_pulse;
		$fell(port_strobe_out_n) |-> ##[1:70] port_strobe_out_n;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("ack pulse too long");
	property p_ack_cause;
		$fell(port_strobe_out_n) |-> $past(port_busy_out);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack before busy");
	property p_busy_cause;
		$rose(port_busy_out) |-> !$past(port_ack_in_n, 2);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy without strobe");

	// ------
	// register bus
	// ------
	property p_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr)
		else $error("no write response");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat)
		else $error("no read response");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read data not held");

	c_ack: cover property ($fell(port_strobe_out_n));
	c_stall: cover property (port_busy_out && port_strobe_out_n [*8]);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ppr_top_asserts

bind ppr_top ppr_top_asserts u_chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .port_ack_in_n, .port_busy_out, .port_strobe_out_n
);

// ==== tb/ppr_sender.sv ====
// ppr_sender: behavioural sending device on the far side of the port
// assumes the bench calls send, one byte at a time
`timescale 1ns/100ps
module ppr_sender (
	input  wire logic       aclk,
	input  wire logic       port_busy_out,
	input  wire logic       port_strobe_out_n,
	output logic      [7:0] port_data_in,
	output logic            port_ack_in_n
);
	initial
	begin
		port_data_in  = 8'h00;
		port_ack_in_n = 1'b1;
	end

	// w: strobe width in cycles; lat: strobe to ack; pw: ack width
	task automatic send(input logic [7:0] b, input int w, output int lat, output int pw);
		lat = 0;
		pw  = 0;
		@(posedge aclk);
		port_data_in <= b;
		repeat (2) @(posedge aclk); // setup before strobe
		port_ack_in_n <= 1'b0;
		do
		begin
			@(posedge aclk);
			lat++;
			if (lat == w)
				port_ack_in_n <= 1'b1;
		end
		while (port_strobe_out_n !== 1'b0);
		do
		begin
			@(posedge aclk);
			pw++;
		end
		while (port_strobe_out_n !== 1'b1);
		// hold is over: lines flip so a stale byte cannot pass
		port_data_in <= ~b;
	endtask : send
endmodule : ppr_sender

// ==== tb/ppr_top_tb.sv ====
// ppr_top_tb: self-checking bench for the parallel receive port
// assumes ppr_top, ppr_sender and the bound checker are compiled first
`timescale 1ns/100ps
module ppr_top_tb;
	logic        aclk          = 1'b0;
	logic        aresetn       = 1'b0;
	logic [7:0]  s_axi_awaddr  = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hF;
	logic        s_axi_wvalid  = 1'b0;
	logic        s_axi_bready  = 1'b0;
	logic [7:0]  s_axi_araddr  = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready  = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0]  port_data_in;
	logic        port_ack_in_n, port_busy_out, port_strobe_out_n, rx_service_req;
	logic [33:0] eq[$];
	logic [7:0]  mq[$];
	int          fail_count  = 0;
	int          checks_done = 0;
	int          seed        = 32'hF2FB;
	int          pw_n        = 3;
	int          lat, lat2, d;
	int          tv[4]       = '{0, 30, 31, 2};
	int          te[4]       = '{1, 30, 30, 2};

	always #2.5 aclk = ~aclk;

	ppr_top dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_data_in, .port_ack_in_n,
		.port_busy_out, .port_strobe_out_n, .rx_service_req
	);
	ppr_sender snd (.aclk, .port_busy_out, .port_strobe_out_n, .port_data_in, .port_ack_in_n);

	// ------
	// tasks
	// ------
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] r = ppr_pkg::RESP_OKAY);
		eq.push_back({r, 32'h0});
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r = ppr_pkg::RESP_OKAY);
		eq.push_back({r, e});
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic pop();
		rd(8'h1C, {24'h0, mq.pop_front()});
	endtask : pop

	task automatic sb(input int w, output int lt);
		logic [7:0] b;
		int         pw;
		b = 8'($random(seed));
		mq.push_back(b);
		snd.send(b, w, lt, pw);
		chk(34'(pw >= 2 * pw_n - 1 && pw <= 2 * pw_n + 1), 34'h1);
	endtask : sb

	// results are compared where they appear, against the oldest note
	always @(posedge aclk)
	begin
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			chk({s_axi_bresp, 32'h0}, eq.pop_front());
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
			chk({s_axi_rresp, s_axi_rdata}, eq.pop_front());
	end

	initial
	begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		final_report();
	end

	// ------
	// scenarios
	// ------
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h18, 32'h8);
		rd(8'h00, 32'h0);
		rd(8'h20, 32'h0, ppr_pkg::RESP_SLVERR);
		wr(8'h20, 32'h1, ppr_pkg::RESP_SLVERR);
		foreach (tv[i])
		begin
			wr(8'h14, tv[i]);
			rd(8'h14, te[i]);
		end
		wr(8'h00, 32'h80);
		wr(8'h08, 32'h3);
		wr(8'h10, 32'h4);
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h9);
		sb(4, lat);
		sb(40, lat);
		chk(34'(lat > 40), 34'h1);
		repeat (3) @(posedge aclk);
		chk(34'(rx_service_req), 34'h1);
		rd(8'h18, 32'h230);
		pop();
		pop();
		chk(34'(rx_service_req), 34'h0);
		pw_n = 9;
		for (int o = 0; o < 5; o++)
		begin
			d = 8 << (2 * o);
			wr(8'h0C, o);
			wr(8'h04, 32'h2);
			sb(4, lat);
			chk(34'(lat >= d && lat <= 2 * d + 20), 34'h1);
			pop();
		end
		wr(8'h0C, 32'h0);
		repeat (30) sb(4, lat);
		rd(8'h18, 32'h1E24);
		fork
			sb(4, lat2);
		join_none
		repeat (200) @(posedge aclk);
		chk(34'(port_busy_out), 34'h1);
		chk(34'(port_strobe_out_n), 34'h1);
		pop();
		wait fork;
		repeat (30) pop();
		rd(8'h18, 32'h28);
		final_report();
	end
endmodule : ppr_top_tb
